// >>> logic/sdram_map.svh
// Constant map for the synchronous DRAM device core
`ifndef SDRAM_MAP_SVH
`define SDRAM_MAP_SVH

// Command pin patterns {cs_n, ras_n, cas_n, we_n}
`define CMDP_NOP       4'h7
`define CMDP_ACTIVE    4'h3
`define CMDP_READ      4'h5
`define CMDP_WRITE     4'h4
`define CMDP_TERMINATE 4'h6
`define CMDP_PRECHARGE 4'h2
`define CMDP_REFRESH   4'h1
`define CMDP_MODE_LOAD 4'h0

// Address and mode-word field positions
`define AUTO_PRE_SELECT_BIT 10
`define MODE_BL_MSB         2
`define MODE_BL_LSB         0
`define MODE_CL_MSB         6
`define MODE_CL_LSB         4
`define MODE_WSINGLE_BIT    9

// Mode values and reset values
`define BL_FULL_PAGE  3'h7
`define CL_THREE      3'h3
`define BL_RESET      3'h0
`define CL3_RESET     1'h1

// Default geometry
`define DQ_WIDTH      16
`define LANE_COUNT    2
`define ADDR_WIDTH    13
`define COL_AW        9
`define ROW_AW        2

`endif

// >>> logic/sdram_pkg.sv
// Types shared by the synchronous DRAM device core
package sdram_pkg;

   typedef enum logic [3:0] {
      CMD_NOP       = 4'b0000,
      CMD_ACTIVE    = 4'b0001,
      CMD_READ      = 4'b0010,
      CMD_WRITE     = 4'b0011,
      CMD_TERMINATE = 4'b0100,
      CMD_PRECHARGE = 4'b0101,
      CMD_REFRESH   = 4'b0110,
      CMD_MODE_LOAD = 4'b0111
   } cmd_t;

   typedef enum logic [1:0] {
      BURST_IDLE  = 2'b00,
      BURST_READ  = 2'b01,
      BURST_WRITE = 2'b10
   } burst_t;

endpackage

// >>> logic/sdram_array.sv
// Storage array: one write port with lane enables, one registered read port
`timescale 1ns/1ns
module sdram_array #(
   parameter int DW    = 16,
   parameter int LANES = 2,
   parameter int AW    = 13
) (
   // Clock
   input  wire logic             ref_clk,
   // Write port
   input  wire logic             wr_en,
   input  wire logic [LANES-1:0] wr_lane,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [DW-1:0]    wr_data,
   // Read port
   input  wire logic             rd_en,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [DW-1:0]    rd_data_q
);

   localparam int LW = DW / LANES;

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // ***************************************************************
   // Lane-masked write
   // ***************************************************************
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge ref_clk) begin
         if (wr_en && wr_lane[g]) begin
            mem[wr_addr][g*LW +: LW] <= wr_data[g*LW +: LW];
         end
      end
   end

   // ***************************************************************
   // Registered read
   // ***************************************************************
   always_ff @(posedge ref_clk) begin
      if (rd_en) begin
         rd_data_q <= mem[rd_addr];
      end
   end

endmodule

// >>> logic/sdram_command_timing.sv
// Synchronous DRAM device core: command decode, bursts, mask and output timing
//
// Summary of operation
// - Column commands may follow every clock
// - Clock enable low suspends one clock later
// - Clock enable high resumes one clock later
// - Write mask blocks same-clock data word
// - Read mask floats lanes two clocks later
// - First write word captured with write command
// - Precharge of the burst's bank or of all banks floats read data after read latency
// - Address bit 10 selects auto precharge, all banks
`timescale 1ns/1ns
`include "sdram_map.svh"
module sdram_command_timing #(
   parameter int DW     = `DQ_WIDTH,
   parameter int LANES  = `LANE_COUNT,
   parameter int ADDR_W = `ADDR_WIDTH,
   parameter int COL_AW = `COL_AW,
   parameter int ROW_AW = `ROW_AW
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   // Command pins
   input  wire logic              cke,
   input  wire logic              cs_n,
   input  wire logic              ras_n,
   input  wire logic              cas_n,
   input  wire logic              we_n,
   input  wire logic [1:0]        ba,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [LANES-1:0]  dqm,
   // Data pins, split into input, output and output enable
   input  wire logic [DW-1:0]     dq_in,
   output logic      [DW-1:0]     dq_out,
   output logic      [LANES-1:0]  dq_oe_n
);

   localparam int MAW = 2 + ROW_AW + COL_AW;

   typedef struct packed {
      logic                        cke;
      logic [2:0]                  bl;
      logic                        cl3;
      logic                        wsingle;
      logic [3:0]                  open;
      logic [3:0][ROW_AW-1:0]      row;
      sdram_pkg::burst_t           burst;
      logic [1:0]                  bank;
      logic [COL_AW-1:0]           col;
      logic [COL_AW-1:0]           cnt;
      logic                        ap;
      logic                        acc_v;
      logic [MAW-1:0]              acc_a;
      logic                        rv1;
      logic [LANES-1:0]            dqm_p1;
      logic [DW-1:0]               dq_out;
      logic [LANES-1:0]            oe_n;
   } state_t;

   state_t            q;
   state_t            d;
   sdram_pkg::cmd_t   cmd;
   logic              rd_now;
   logic              wr_now;
   logic [MAW-1:0]    word_a;
   logic              mem_re_v;
   logic [MAW-1:0]    mem_ra;
   logic [DW-1:0]     mem_rdata;
   logic [COL_AW-1:0] mask;
   logic              full;

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic sdram_pkg::cmd_t decode(input logic [3:0] p);
      if (p == `CMDP_ACTIVE) begin
         return sdram_pkg::CMD_ACTIVE;
      end else if (p == `CMDP_READ) begin
         return sdram_pkg::CMD_READ;
      end else if (p == `CMDP_WRITE) begin
         return sdram_pkg::CMD_WRITE;
      end else if (p == `CMDP_TERMINATE) begin
         return sdram_pkg::CMD_TERMINATE;
      end else if (p == `CMDP_PRECHARGE) begin
         return sdram_pkg::CMD_PRECHARGE;
      end else if (p == `CMDP_REFRESH) begin
         return sdram_pkg::CMD_REFRESH;
      end else if (p == `CMDP_MODE_LOAD) begin
         return sdram_pkg::CMD_MODE_LOAD;
      end else begin
         return sdram_pkg::CMD_NOP;
      end
   endfunction

   // Sequential wrap inside the burst-length block
   function automatic logic [COL_AW-1:0] next_col(input logic [COL_AW-1:0] c,
                                                   input logic [COL_AW-1:0] m);
      logic [COL_AW-1:0] inc;
      inc = c + COL_AW'(1);
      return (c & ~m) | (inc & m);
   endfunction

   // Reserved length codes take the full-page mask, but their bursts end after one page instead of wrapping
   function automatic logic [COL_AW-1:0] len_mask(input logic [2:0] bl);
      if (bl > 3'h3) begin
         return '1;
      end else begin
         return COL_AW'((1 << bl) - 1);
      end
   endfunction

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      d        = q;
      cmd      = decode({cs_n, ras_n, cas_n, we_n});
      rd_now   = 1'b0;
      wr_now   = 1'b0;
      word_a   = {q.bank, q.row[q.bank], q.col};
      full     = (q.bl == `BL_FULL_PAGE);
      mask     = len_mask(q.bl);
      // Clock enable is registered, so the cycle that samples it low still runs
      d.cke    = cke;
      if (q.cke) begin
         d.dqm_p1 = dqm;
         // Running burst: any column command, terminate or a precharge
         // that hits this bank stops it before the word is issued
         if (q.burst != sdram_pkg::BURST_IDLE) begin
            if (cmd == sdram_pkg::CMD_READ || cmd == sdram_pkg::CMD_WRITE ||
                cmd == sdram_pkg::CMD_TERMINATE ||
                (cmd == sdram_pkg::CMD_PRECHARGE &&
                 (addr[`AUTO_PRE_SELECT_BIT] || ba == q.bank))) begin
               d.burst = sdram_pkg::BURST_IDLE;
            end else begin
               rd_now = (q.burst == sdram_pkg::BURST_READ);
               wr_now = (q.burst == sdram_pkg::BURST_WRITE);
               if (q.burst == sdram_pkg::BURST_WRITE && q.wsingle) begin
                  d.burst = sdram_pkg::BURST_IDLE;
               end else if (!full && q.cnt == mask) begin
                  d.burst = sdram_pkg::BURST_IDLE;
                  if (q.ap) begin
                     d.open[q.bank] = 1'b0;
                  end
               end else begin
                  d.col = next_col(q.col, mask);
                  d.cnt = q.cnt + COL_AW'(1);
               end
            end
         end
         case (cmd)
            sdram_pkg::CMD_ACTIVE: begin
               d.open[ba] = 1'b1;
               d.row[ba]  = addr[ROW_AW-1:0];
            end
            sdram_pkg::CMD_READ, sdram_pkg::CMD_WRITE: begin
               if (q.open[ba]) begin
                  rd_now  = (cmd == sdram_pkg::CMD_READ);
                  wr_now  = (cmd == sdram_pkg::CMD_WRITE);
                  word_a  = {ba, q.row[ba], addr[COL_AW-1:0]};
                  d.bank  = ba;
                  d.ap    = addr[`AUTO_PRE_SELECT_BIT];
                  d.col   = next_col(addr[COL_AW-1:0], mask);
                  d.cnt   = COL_AW'(1);
                  if ((!full && mask == '0) ||
                      (cmd == sdram_pkg::CMD_WRITE && q.wsingle)) begin
                     d.burst = sdram_pkg::BURST_IDLE;
                     if (addr[`AUTO_PRE_SELECT_BIT]) begin
                        d.open[ba] = 1'b0;
                     end
                  end else if (cmd == sdram_pkg::CMD_READ) begin
                     d.burst = sdram_pkg::BURST_READ;
                  end else begin
                     d.burst = sdram_pkg::BURST_WRITE;
                  end
               end
            end
            sdram_pkg::CMD_PRECHARGE: begin
               if (addr[`AUTO_PRE_SELECT_BIT]) begin
                  d.open = 4'h0;
               end else begin
                  d.open[ba] = 1'b0;
               end
            end
            sdram_pkg::CMD_MODE_LOAD: begin
               // Ignored while any row is open, which keeps a running
               // burst from changing length or latency under its feet
               if (q.open == 4'h0) begin
                  d.bl      = addr[`MODE_BL_MSB:`MODE_BL_LSB];
                  d.cl3     = (addr[`MODE_CL_MSB:`MODE_CL_LSB] == `CL_THREE);
                  d.wsingle = addr[`MODE_WSINGLE_BIT];
               end
            end
            default: begin
            end
         endcase
         // Latency three holds the array access back by one clock
         d.acc_v  = rd_now;
         d.acc_a  = word_a;
         d.rv1    = mem_re_v;
         d.dq_out = mem_rdata;
         // Mask sampled with the access word gates lanes two clocks on
         d.oe_n   = q.rv1 ? q.dqm_p1 : '1;
      end
   end

   assign mem_re_v = q.cl3 ? q.acc_v : rd_now;
   assign mem_ra   = q.cl3 ? q.acc_a : word_a;

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         q         <= '0;
         q.bl      <= `BL_RESET;
         q.cl3     <= `CL3_RESET;
         q.burst   <= sdram_pkg::BURST_IDLE;
         q.oe_n    <= '1;
      end else begin
         q <= d;
      end
   end

   // ***************************************************************
   // Storage
   // ***************************************************************
   sdram_array #(
      .DW    (DW),
      .LANES (LANES),
      .AW    (MAW)
   ) u_array (
      .ref_clk   (ref_clk),
      .wr_en     (q.cke && wr_now),
      .wr_lane   (~dqm),
      .wr_addr   (word_a),
      .wr_data   (dq_in),
      .rd_en     (q.cke),
      .rd_addr   (mem_ra),
      .rd_data_q (mem_rdata)
   );

   assign dq_out  = q.dq_out;
   assign dq_oe_n = q.oe_n;

endmodule

// >>> test/sdram_command_timing_props.sv
// Concurrent checks on the device core pins
`timescale 1ns/1ns
`include "sdram_map.svh"
module sdram_command_timing_props #(
   parameter int DW     = 16,
   parameter int LANES  = 2,
   parameter int ADDR_W = 13
) (
   // Clock and reset
   input wire logic              ref_clk,
   input wire logic              resetn,
   // Command pins
   input wire logic              cke,
   input wire logic              cs_n,
   input wire logic              ras_n,
   input wire logic              cas_n,
   input wire logic              we_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [LANES-1:0]  dqm,
   // Read data
   input wire logic [DW-1:0]     dq_out,
   input wire logic [LANES-1:0]  dq_oe_n
);
   logic [3:0] cmd;
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Edge at which a command is taken
   sequence s_live; $past(cke) && cke; endsequence
   // No read for two live edges, so only piped words may still leave
   sequence s_calm; (cke && cmd != `CMDP_READ)[*2]; endsequence
   a_reset_float:
      assert property (disable iff (1'b0) !resetn |=> &dq_oe_n) else $error("lanes driven in reset");
   a_reset_data:
      assert property (disable iff (1'b0) !resetn |=> dq_out == '0) else $error("data not cleared");
   a_read_mask:
      assert property (s_live ##0 (|dqm) ##1 cke |=> (dq_oe_n & $past(dqm, 2)) == $past(dqm, 2))
      else $error("read mask did not float lane");
   a_pre_release:
      assert property (s_live ##0 (cmd == `CMDP_PRECHARGE && addr[`AUTO_PRE_SELECT_BIT])
         ##1 s_calm |=> &dq_oe_n) else $error("precharge did not release data");
   a_term_release:
      assert property (s_live ##0 (cmd == `CMDP_TERMINATE) ##1 s_calm |=> &dq_oe_n)
      else $error("terminate did not release data");
   a_freeze_hold:
      assert property (!cke |-> ##2 ($stable(dq_out) && $stable(dq_oe_n)))
      else $error("outputs moved while suspended");
   a_resume_late:
      assert property (!cke ##1 cke |-> ##1 $stable(dq_oe_n)) else $error("resumed too early");
   a_read_drives:
      assert property (s_live ##0 (cmd == `CMDP_READ && dqm == '0) ##1 (cke && dqm == '0)[*2]
         |-> ##[0:1] dq_oe_n == '0) else $error("read data not driven");
endmodule
bind sdram_command_timing sdram_command_timing_props #(.DW(DW), .LANES(LANES), .ADDR_W(ADDR_W))
   props (.ref_clk, .resetn, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .dqm, .dq_out, .dq_oe_n);

// >>> test/sdram_ctrl_model.sv
// Controller-side model driving the device command and write-data pins
`timescale 1ns/1ns
`include "sdram_map.svh"
module sdram_ctrl_model (
   // Clock
   input  wire logic   ref_clk,
   // Command pins
   output logic        cke,
   output logic        cs_n,
   output logic        ras_n,
   output logic        cas_n,
   output logic        we_n,
   output logic [1:0]  ba,
   output logic [12:0] addr,
   output logic [1:0]  dqm,
   // Write data
   output logic [15:0] dq_in
);
   initial begin
      {cs_n, ras_n, cas_n, we_n} = `CMDP_NOP;
      {cke, ba, addr, dqm, dq_in} = {1'b1, 2'h0, 13'h0000, 2'h0, 16'h0000};
   end
   // One command per cycle from the falling edge; unused data is inverted so a
   // stale word can never pass for fresh write data
   task automatic cmd(input logic [3:0] p, input logic [1:0] b, input logic [12:0] a,
                      input logic [1:0] m, input logic [15:0] d, input logic dv, input logic k);
      {cs_n, ras_n, cas_n, we_n} = p;
      {ba, addr, dqm, cke} = {b, a, m, k};
      dq_in = dv ? d : ~dq_in;
      @(negedge ref_clk);
   endtask
   // Spacing waits, counts rounded up at 20 ns
   task automatic idle(input int n);
      repeat (n) cmd(`CMDP_NOP, ba, addr, 2'h0, dq_in, 1'b0, 1'b1);
   endtask
   // 100 us pause, then two refreshes spaced by the refresh period
   task automatic power_up();
      idle(5000);
      repeat (2) begin
         cmd(`CMDP_REFRESH, ba, addr, 2'h0, dq_in, 1'b0, 1'b1);
         idle(4);
      end
   endtask
endmodule

// >>> test/sdram_command_timing_tb.sv
// Self-checking bench for the synchronous DRAM device core
`timescale 1ns/1ns
`include "sdram_map.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
   $display("FAIL %s expected %h seen %h", n, e, s); end end
module sdram_command_timing_tb;
   logic        ref_clk, resetn, cke, cs_n, ras_n, cas_n, we_n;
   logic [1:0]  ba, dqm, dq_oe_n;
   logic [12:0] addr;
   logic [15:0] dq_in, dq_out;
   int          fail_count = 0;
   int          checks = 0;
   logic [15:0] exp_w [2] = '{16'hAAAA, 16'h1255};

   sdram_command_timing dut (.ref_clk, .resetn, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
      .addr, .dqm, .dq_in, .dq_out, .dq_oe_n);
   sdram_ctrl_model ctl (.ref_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dqm, .dq_in);

   task automatic c(input logic [3:0] p, input logic [12:0] a, input logic [1:0] m = 2'h0,
                    input logic [15:0] d = 16'h0000, input logic dv = 1'b0,
                    input logic k = 1'b1, input logic [1:0] b = 2'h1);
      ctl.cmd(p, b, a, m, d, dv, k);
   endtask

   task automatic close_out();
      if (fail_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Back-to-back writes with a lane mask, back-to-back reads at latency 3
   task automatic t_write_read();
      c(`CMDP_ACTIVE, 13'h0000);
      ctl.idle(1);
      c(`CMDP_WRITE, 13'h0000, 2'h0, 16'hAAAA, 1'b1);
      c(`CMDP_WRITE, 13'h0001, 2'h0, 16'h1234, 1'b1);
      c(`CMDP_WRITE, 13'h0001, 2'h2, 16'h5555, 1'b1);
      ctl.idle(1);
      for (int i = 0; i < 5; i++) begin
         c(i < 2 ? `CMDP_READ : `CMDP_NOP, 13'(i));
         if (i inside {[2:3]}) `CHK("read word", exp_w[i-2], dq_out)
      end
      // Only the mask of the edge after the read may reach the lanes
      for (int i = 0; i < 4; i++) begin
         c(i == 0 ? `CMDP_READ : `CMDP_NOP, 13'h0000, i == 1 ? 2'h2 : 2'h0);
         if (i == 2) `CHK("masked lanes", 2'h2, dq_oe_n)
      end
   endtask

   // Auto precharge must close the bank, or the latency-2 mode load is refused
   task automatic t_auto_pre();
      c(`CMDP_READ, 13'h0400);
      ctl.idle(3);
      c(`CMDP_MODE_LOAD, 13'h0021);
      ctl.idle(2);
      c(`CMDP_ACTIVE, 13'h0000);
      ctl.idle(1);
      for (int i = 0; i < 5; i++) begin
         c(i == 0 ? `CMDP_READ : `CMDP_NOP, 13'h0000);
         if (i inside {[1:2]}) `CHK("latency 2 word", exp_w[i-1], dq_out)
         if (i == 3) `CHK("burst end", 2'h3, dq_oe_n)
      end
      c(`CMDP_PRECHARGE, 13'h0400);
      ctl.idle(3);
   endtask

   // Clock enable dropped one edge after a read holds the first word through the stall;
   // then a precharge of another bank must not cut a burst, an all-bank one must
   task automatic t_freeze();
      c(`CMDP_ACTIVE, 13'h0000);
      ctl.idle(1);
      for (int i = 0; i < 8; i++) begin
         c(i == 0 ? `CMDP_READ : `CMDP_NOP, 13'h0000, 2'h0, 16'h0000, 1'b0, !(i inside {[1:3]}));
         if (i inside {[1:5]}) `CHK("suspended lanes", 2'h0, dq_oe_n)
         if (i inside {[1:5]}) `CHK("resumed word", exp_w[i/5], dq_out)
         if (i == 6) `CHK("stall end", 2'h3, dq_oe_n)
      end
      c(`CMDP_READ, 13'h0000);
      c(`CMDP_PRECHARGE, 13'h0000, 2'h0, 16'h0000, 1'b0, 1'b1, 2'h0);
      c(`CMDP_NOP, 13'h0000);
      `CHK("other bank precharge", exp_w[1], dq_out)
      c(`CMDP_READ, 13'h0000);
      c(`CMDP_PRECHARGE, 13'h0400);
      `CHK("cut word", exp_w[0], dq_out)
      c(`CMDP_NOP, 13'h0000);
      `CHK("cut release", 2'h3, dq_oe_n)
      c(`CMDP_TERMINATE, 13'h0000);
      ctl.idle(3);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      resetn = 1'b0;
      repeat (10) @(negedge ref_clk);
      `CHK("reset lanes", 2'h3, dq_oe_n)
      `CHK("reset data", 16'h0000, dq_out)
      resetn = 1'b1;
      ctl.power_up();
      t_write_read();
      t_auto_pre();
      t_freeze();
      close_out();
   end

   // Power-up alone takes about 5000 cycles
   initial begin
      repeat (8000) @(posedge ref_clk);
      fail_count++;
      close_out();
   end
endmodule
